// ===== src/ppf_pkg.sv
// package: register map, field positions and reset values of the port function block
package ppf_pkg;
    localparam int ADDR_W = 16;
    localparam int DATA_W = 8;
    // register byte addresses
    localparam logic [15:0] OFF_FUNC_CTRL_1 = 16'hFF45;
    localparam logic [15:0] OFF_P1_PIN = 16'hFF50;
    localparam logic [15:0] OFF_P4_PIN = 16'hFF53;
    localparam logic [15:0] OFF_PC_PIN = 16'hFF5B;
    localparam logic [15:0] OFF_PF_PIN = 16'hFF5E;
    localparam logic [15:0] OFF_PG_PIN = 16'hFF5F;
    localparam logic [15:0] OFF_P1_LATCH = 16'hFF60;
    localparam logic [15:0] OFF_P2_LATCH = 16'hFF61;
    localparam logic [15:0] OFF_P3_LATCH = 16'hFF62;
    localparam logic [15:0] OFF_PA_LATCH = 16'hFF69;
    localparam logic [15:0] OFF_PB_LATCH = 16'hFF6A;
    // reset values
    localparam logic [7:0] RST_FUNC_CTRL_1 = 8'h0F;
    localparam logic [7:0] RST_LATCH = 8'h00;
    // field positions in port_function_ctrl_1
    localparam int FLD_ADDR_EN_LSB = 0;
    localparam int FLD_F0_CS4 = 4;
    localparam int FLD_F1_CS5 = 5;
    localparam int FLD_CS36 = 6;
    localparam int FLD_CS17 = 7;
    // implemented bits
    localparam logic [7:0] MASK_P3 = 8'h3F;
    localparam logic [7:0] MASK_PA = 8'h0F;
    localparam logic [7:0] MASK_PG = 8'h1F;
    // operating modes where pin functions apply
    localparam logic [2:0] MODE_LO = 3'h4;
    localparam logic [2:0] MODE_HI = 3'h6;
endpackage

// ===== src/ppf_sync.sv
// two-flop synchroniser for a bus of pin levels
`timescale 1ns/1ps
module ppf_sync #(
    parameter int W = 8
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] meta_r;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_r <= '0;
            q_o <= '0;
        end else begin
            meta_r <= d_i;
            q_o <= meta_r;
        end
    end
endmodule

// ===== src/ppf_port_ctrl.sv
// port pin state, output latches and pin function selection, wishbone slave
//
// The Wishbone slave port was decided locally.
`timescale 1ns/1ps

// Notes on behaviour
// - address enable set and port 1 direction set drives address line A20-A23.
// - address enable clear with direction set drives port 1 latch value.
// - function control resets to low nibble ones, upper nibble zeros.
// - F0 select drives chip select 4 if no bus release, cs2-5 enable, direction.
// - F1 select drives chip select 5 under the same three conditions.
// - G1 gives chip select 3 or 6 per swap bit, gated by enable, direction.
// - G3 gives chip select 1 or 7 per swap bit, gated by cs1/6/7 and direction.
// - pin function selections apply only in operating modes 4, 5 and 6.
// - pin-state registers are read-only and return live pin levels.
// - port G pin state holds G4-G0 in bits 4-0; upper bits read zero.
// - output latches are read/write, drive pins, reset to zero.
// - port 3 latch implements bits 5-0 only; bits 7-6 read zero.
module ppf_port_ctrl (
    // system
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ppf_pkg::ADDR_W-1:0] wb_adr_i,
    input wire logic wb_sel_i,
    input wire logic [ppf_pkg::DATA_W-1:0] wb_dat_i,
    output logic [ppf_pkg::DATA_W-1:0] wb_dat_o,
    output logic wb_ack_o,
    output logic wb_err_o,
    // surrounding control logic
    input wire logic [7:0] port_1_dir_i,
    input wire logic [7:0] port_2_dir_i,
    input wire logic [7:0] port_3_dir_i,
    input wire logic [7:0] port_a_dir_i,
    input wire logic [7:0] port_b_dir_i,
    input wire logic [7:0] port_f_dir_i,
    input wire logic [7:0] port_g_dir_i,
    input wire logic bus_release_enable_i,
    input wire logic chip_select_2_to_5_enable_i,
    input wire logic chip_select_1_6_7_enable_i,
    input wire logic [2:0] op_mode_i,
    input wire logic [3:0] addr_hi_i,
    input wire logic [7:1] chip_select_i,
    // pin levels
    input wire logic [7:0] port_1_pin_i,
    input wire logic [7:0] port_4_pin_i,
    input wire logic [7:0] port_c_pin_i,
    input wire logic [7:0] port_f_pin_i,
    input wire logic [4:0] port_g_pin_i,
    // pin drive
    output logic [7:0] port_1_o,
    output logic [7:0] port_1_oe_o,
    output logic [7:0] port_2_o,
    output logic [7:0] port_2_oe_o,
    output logic [5:0] port_3_o,
    output logic [5:0] port_3_oe_o,
    output logic [3:0] port_a_o,
    output logic [3:0] port_a_oe_o,
    output logic [7:0] port_b_o,
    output logic [7:0] port_b_oe_o,
    output logic [1:0] port_f_cs_o,
    output logic [1:0] port_f_cs_oe_o,
    output logic [1:0] port_g_cs_o,
    output logic [1:0] port_g_cs_oe_o
);
    import ppf_pkg::*;

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [7:0] func_ctrl_r;
    logic [7:0] p1_latch_r;
    logic [7:0] p2_latch_r;
    logic [7:0] p3_latch_r;
    logic [7:0] pa_latch_r;
    logic [7:0] pb_latch_r;
    logic ack_r;
    logic err_r;
    logic [7:0] rdat_r;
    logic [7:0] p1_s;
    logic [7:0] p4_s;
    logic [7:0] pc_s;
    logic [7:0] pf_s;
    logic [4:0] pg_s;

    // pins are asynchronous to the core clock
    ppf_sync #(.W(8)) u_sync_p1 (.clk_i(clk_i), .rst_i(rst_i), .d_i(port_1_pin_i), .q_o(p1_s));
    ppf_sync #(.W(8)) u_sync_p4 (.clk_i(clk_i), .rst_i(rst_i), .d_i(port_4_pin_i), .q_o(p4_s));
    ppf_sync #(.W(8)) u_sync_pc (.clk_i(clk_i), .rst_i(rst_i), .d_i(port_c_pin_i), .q_o(pc_s));
    ppf_sync #(.W(8)) u_sync_pf (.clk_i(clk_i), .rst_i(rst_i), .d_i(port_f_pin_i), .q_o(pf_s));
    ppf_sync #(.W(5)) u_sync_pg (.clk_i(clk_i), .rst_i(rst_i), .d_i(port_g_pin_i), .q_o(pg_s));

    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    wire req = wb_cyc_i && wb_stb_i && !ack_r && !err_r;
    wire wr = req && wb_we_i && wb_sel_i;
    wire hit_fc = wb_adr_i == OFF_FUNC_CTRL_1;
    wire hit_l1 = wb_adr_i == OFF_P1_LATCH;
    wire hit_l2 = wb_adr_i == OFF_P2_LATCH;
    wire hit_l3 = wb_adr_i == OFF_P3_LATCH;
    wire hit_la = wb_adr_i == OFF_PA_LATCH;
    wire hit_lb = wb_adr_i == OFF_PB_LATCH;
    wire hit_s1 = wb_adr_i == OFF_P1_PIN;
    wire hit_s4 = wb_adr_i == OFF_P4_PIN;
    wire hit_sc = wb_adr_i == OFF_PC_PIN;
    wire hit_sf = wb_adr_i == OFF_PF_PIN;
    wire hit_sg = wb_adr_i == OFF_PG_PIN;
    wire hit_rw = hit_fc | hit_l1 | hit_l2 | hit_l3 | hit_la | hit_lb;
    wire hit_ro = hit_s1 | hit_s4 | hit_sc | hit_sf | hit_sg;
    // writes to read-only state registers are ignored but acknowledged
    wire mapped = hit_rw | hit_ro;

    wire [7:0] rd_mux =
        hit_fc ? func_ctrl_r :
        hit_l1 ? p1_latch_r :
        hit_l2 ? p2_latch_r :
        hit_l3 ? (p3_latch_r & MASK_P3) :
        hit_la ? (pa_latch_r & MASK_PA) :
        hit_lb ? pb_latch_r :
        hit_s1 ? p1_s :
        hit_s4 ? p4_s :
        hit_sc ? pc_s :
        hit_sf ? pf_s :
        hit_sg ? {3'h0, pg_s} : 8'h00;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_r <= 1'b0;
            err_r <= 1'b0;
            rdat_r <= 8'h00;
        end else begin
            ack_r <= req && mapped;
            err_r <= req && !mapped;
            rdat_r <= req ? rd_mux : 8'h00;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            func_ctrl_r <= RST_FUNC_CTRL_1;
            p1_latch_r <= RST_LATCH;
            p2_latch_r <= RST_LATCH;
            p3_latch_r <= RST_LATCH;
            pa_latch_r <= RST_LATCH;
            pb_latch_r <= RST_LATCH;
        end else if (wr) begin
            if (hit_fc) func_ctrl_r <= wb_dat_i;
            if (hit_l1) p1_latch_r <= wb_dat_i;
            if (hit_l2) p2_latch_r <= wb_dat_i;
            if (hit_l3) p3_latch_r <= wb_dat_i & MASK_P3;
            if (hit_la) pa_latch_r <= wb_dat_i & MASK_PA;
            if (hit_lb) pb_latch_r <= wb_dat_i;
        end
    end

    assign wb_ack_o = ack_r;
    assign wb_err_o = err_r;
    assign wb_dat_o = rdat_r;

    // ------------------------------------------------------------
    // pin function selection
    // ------------------------------------------------------------
    // mode and enables are core-clock signals; no synchroniser needed
    wire fn_mode = (op_mode_i >= MODE_LO) && (op_mode_i <= MODE_HI);
    wire [3:0] a_en = func_ctrl_r[FLD_ADDR_EN_LSB +: 4] & {4{fn_mode}};
    wire cs_f0 = fn_mode && func_ctrl_r[FLD_F0_CS4];
    wire cs_f1 = fn_mode && func_ctrl_r[FLD_F1_CS5];
    wire swap36 = func_ctrl_r[FLD_CS36];
    wire swap17 = func_ctrl_r[FLD_CS17];
    wire cs25_ok = !bus_release_enable_i && chip_select_2_to_5_enable_i;
    // swap bits assume software released the direction bit first
    wire g1_en = fn_mode && (swap36 ? chip_select_1_6_7_enable_i
                                    : chip_select_2_to_5_enable_i);
    wire g3_en = fn_mode && chip_select_1_6_7_enable_i;

    logic [7:0] p1_nxt;
    always_comb begin
        p1_nxt = p1_latch_r;
        for (int i = 0; i < 4; i++) begin
            if (a_en[i]) p1_nxt[i] = addr_hi_i[i];
        end
    end

    // ------------------------------------------------------------
    // registered pin drive
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            port_1_o <= 8'h00;
            port_1_oe_o <= 8'h00;
            port_2_o <= 8'h00;
            port_2_oe_o <= 8'h00;
            port_3_o <= 6'h00;
            port_3_oe_o <= 6'h00;
            port_a_o <= 4'h0;
            port_a_oe_o <= 4'h0;
            port_b_o <= 8'h00;
            port_b_oe_o <= 8'h00;
            port_f_cs_o <= 2'h0;
            port_f_cs_oe_o <= 2'h0;
            port_g_cs_o <= 2'h0;
            port_g_cs_oe_o <= 2'h0;
        end else begin
            port_1_o <= p1_nxt;
            port_1_oe_o <= port_1_dir_i;
            port_2_o <= p2_latch_r;
            port_2_oe_o <= port_2_dir_i;
            port_3_o <= p3_latch_r[5:0];
            port_3_oe_o <= port_3_dir_i[5:0];
            port_a_o <= pa_latch_r[3:0];
            port_a_oe_o <= port_a_dir_i[3:0];
            port_b_o <= pb_latch_r;
            port_b_oe_o <= port_b_dir_i;
            port_f_cs_o <= {chip_select_i[5], chip_select_i[4]};
            port_f_cs_oe_o <= {cs_f1 && cs25_ok && port_f_dir_i[1],
                               cs_f0 && cs25_ok && port_f_dir_i[0]};
            port_g_cs_o <= {swap17 ? chip_select_i[7] : chip_select_i[1],
                            swap36 ? chip_select_i[6] : chip_select_i[3]};
            port_g_cs_oe_o <= {g3_en && port_g_dir_i[3], g1_en && port_g_dir_i[1]};
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_reset_func_ctrl: assert property (@(posedge clk_i)
        $fell(rst_i) |-> func_ctrl_r == RST_FUNC_CTRL_1)
        else $error("function control reset value wrong");
    a_addr_line_drive: assert property (@(posedge clk_i) disable iff (rst_i)
        (fn_mode && func_ctrl_r[0]) |=> port_1_o[0] == $past(addr_hi_i[0]))
        else $error("address line 20 not driven");
    a_latch_drive_p1: assert property (@(posedge clk_i) disable iff (rst_i)
        !func_ctrl_r[1] |=> port_1_o[1] == $past(p1_latch_r[1]))
        else $error("port 1 latch not driven");
    a_cs4_gate: assert property (@(posedge clk_i) disable iff (rst_i)
        (bus_release_enable_i || !func_ctrl_r[FLD_F0_CS4]) |=> !port_f_cs_oe_o[0])
        else $error("chip select 4 enabled wrongly");
    a_cs5_gate: assert property (@(posedge clk_i) disable iff (rst_i)
        (fn_mode && cs_f1 && cs25_ok && port_f_dir_i[1]) |=> port_f_cs_oe_o[1])
        else $error("chip select 5 not enabled");
    a_g1_select: assert property (@(posedge clk_i) disable iff (rst_i)
        !swap36 |=> port_g_cs_o[0] == $past(chip_select_i[3]))
        else $error("pin g1 chip select mismatch");
    a_g3_gate: assert property (@(posedge clk_i) disable iff (rst_i)
        !chip_select_1_6_7_enable_i |=> !port_g_cs_oe_o[1])
        else $error("pin g3 driven without enable");
    a_mode_gate: assert property (@(posedge clk_i) disable iff (rst_i)
        !fn_mode |=> (port_f_cs_oe_o == 2'h0 && port_g_cs_oe_o == 2'h0
                      && port_1_o == $past(p1_latch_r)))
        else $error("pin function outside modes 4-6");
    a_pg_upper_zero: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_ack_o && $past(hit_sg) |-> wb_dat_o[7:5] == 3'h0)
        else $error("port g upper bits not zero");
    a_p3_direction: assert property (@(posedge clk_i) disable iff (rst_i)
        port_3_dir_i == 8'h00 |=> port_3_oe_o == 6'h00)
        else $error("port 3 driven as input");
    a_ack_one_cycle: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");

    c_write_ctrl: cover property (@(posedge clk_i) wr && hit_fc);
    c_cs7_out: cover property (@(posedge clk_i) port_g_cs_oe_o[1] && swap17);
    c_unmapped: cover property (@(posedge clk_i) wb_err_o);
    c_addr_out: cover property (@(posedge clk_i) fn_mode && a_en == 4'hF && port_1_oe_o[3]);
endmodule

// ===== tb/ppf_pin_model.sv
// board model: package pin levels from the device drive and outside sources
`timescale 1ns/1ps
module ppf_pin_model (
    // device drive
    input wire logic [7:0] p1_i,
    input wire logic [7:0] p1_oe_i,
    input wire logic [3:0] cs_i,
    input wire logic [3:0] cs_oe_i,
    // outside sources, the bench sets them once to a random value
    input wire logic [39:0] ext_i,
    // pin levels seen by the device
    output logic [7:0] p1_pin_o,
    output logic [7:0] p4_pin_o,
    output logic [7:0] pc_pin_o,
    output logic [7:0] pf_pin_o,
    output logic [4:0] pg_pin_o
);
    // a released pin shows the outside level, never the last driven value
    wire logic [3:0] cs_ext = {ext_i[35], ext_i[33], ext_i[25:24]};
    wire logic [3:0] cs_pin = (cs_oe_i & cs_i) | (~cs_oe_i & cs_ext);
    assign p1_pin_o = (p1_oe_i & p1_i) | (~p1_oe_i & ext_i[7:0]);
    assign p4_pin_o = ext_i[15:8];
    assign pc_pin_o = ext_i[23:16];
    assign pf_pin_o = {ext_i[31:26], cs_pin[1:0]};
    assign pg_pin_o = {ext_i[36], cs_pin[3], ext_i[34], cs_pin[2], ext_i[32]};
endmodule

// ===== tb/ppf_port_ctrl_tb.sv
// self-checking bench for the port pin state and pin function block
`timescale 1ns/1ps
module ppf_port_ctrl_tb;
    import ppf_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0, sel = 1'b0, ack, err;
    logic [15:0] adr = '0;
    logic [7:0] wdat = '0, rdat, pfc, l1, rd, cs_exp;
    logic [7:0] d1 = '0, d2 = '0, d3 = '0, da = '0, db = '0, df = '0, dg = '0;
    logic bus_release_enable = 1'b0, e25 = 1'b0, e167 = 1'b0;
    logic [2:0] mode = '0;
    logic [3:0] ahi = '0;
    logic [7:1] cs = '0;
    logic [39:0] ext = '0;
    logic [7:0] p1, p1e, p2, p2e, pb, pbe, q1, q4, qc, qf;
    logic [5:0] p3, p3e;
    logic [3:0] pa, pae;
    logic [1:0] fc, fce, gc, gce;
    logic [4:0] qg;
    logic [7:0] lv [5];
    logic [7:0] pe [5];
    logic [15:0] la [5] = '{OFF_P1_LATCH, OFF_P2_LATCH, OFF_P3_LATCH, OFF_PA_LATCH, OFF_PB_LATCH};
    logic [15:0] ps [5] = '{OFF_P1_PIN, OFF_P4_PIN, OFF_PC_PIN, OFF_PF_PIN, OFF_PG_PIN};
    logic [7:0] lm [5] = '{8'hFF, 8'hFF, 8'h3F, 8'h0F, 8'hFF};
    int error_cnt = 0;
    int total_checks = 0;

    ppf_port_ctrl ppf_port_ctrl_inst (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rd), .wb_ack_o(ack),
        .wb_err_o(err), .port_1_dir_i(d1), .port_2_dir_i(d2), .port_3_dir_i(d3),
        .port_a_dir_i(da), .port_b_dir_i(db), .port_f_dir_i(df), .port_g_dir_i(dg),
        .bus_release_enable_i(bus_release_enable), .chip_select_2_to_5_enable_i(e25),
        .chip_select_1_6_7_enable_i(e167), .op_mode_i(mode), .addr_hi_i(ahi),
        .chip_select_i(cs), .port_1_pin_i(q1), .port_4_pin_i(q4), .port_c_pin_i(qc),
        .port_f_pin_i(qf), .port_g_pin_i(qg), .port_1_o(p1), .port_1_oe_o(p1e),
        .port_2_o(p2), .port_2_oe_o(p2e), .port_3_o(p3), .port_3_oe_o(p3e), .port_a_o(pa),
        .port_a_oe_o(pae), .port_b_o(pb), .port_b_oe_o(pbe), .port_f_cs_o(fc),
        .port_f_cs_oe_o(fce), .port_g_cs_o(gc), .port_g_cs_oe_o(gce));
    ppf_pin_model ppf_pin_model_inst (.p1_i(p1), .p1_oe_i(p1e), .cs_i({gc, fc}),
        .cs_oe_i({gce, fce}), .ext_i(ext), .p1_pin_o(q1), .p4_pin_o(q4), .pc_pin_o(qc),
        .pf_pin_o(qf), .pg_pin_o(qg));

    always #5 clk_i = ~clk_i;

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // one classic cycle; ack and read data are taken at the rising edge that samples ack high
    task automatic wb(input int w, input logic [15:0] a, input logic [7:0] d, input logic bad);
        int n;
        n = 0;
        @(posedge clk_i);
        {cyc, stb, we, sel, adr, wdat} <= {2'h3, w[0], 1'b1, a, d};
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && err !== 1'b1 && n < 20);
        rdat = rd;
        chk({6'h0, err, ack}, {6'h0, bad, !bad});
        {cyc, stb, we, sel} <= 4'h0;
    endtask

    task automatic settle;
        repeat (3) @(negedge clk_i);
    endtask

    function automatic logic [7:0] exp_p1(input logic [7:0] p, l, input logic [3:0] a,
                                          input logic [2:0] m);
        exp_p1 = l;
        for (int i = 0; i < 4; i++) begin
            if (m >= 3'h4 && m <= 3'h6 && p[i]) exp_p1[i] = a[i];
        end
    endfunction

    // packed as {oe G3, oe G1, oe F1, oe F0, values masked by their enables}
    function automatic logic [7:0] exp_cs(input logic [7:0] p, f, g, input logic br, c25, c167,
                                          input logic [2:0] m, input logic [7:1] c);
        logic on;
        logic [3:0] oe, v;
        on = m >= 3'h4 && m <= 3'h6;
        oe[0] = on & p[4] & !br & c25 & f[0];
        oe[1] = on & p[5] & !br & c25 & f[1];
        oe[2] = on & g[1] & (p[6] ? c167 : c25);
        oe[3] = on & g[3] & c167;
        v = {p[7] ? c[7] : c[1], p[6] ? c[6] : c[3], c[5], c[4]};
        exp_cs = {oe, v & oe};
    endfunction

    task automatic summarize;
        $display("errors %0d checks %0d", error_cnt, total_checks);
        if (error_cnt == 0 && total_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    initial begin
        repeat (5000) @(posedge clk_i);
        error_cnt++;
        summarize();
    end

    initial begin
        void'($urandom(32'hB3D1));
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(0, OFF_FUNC_CTRL_1, 8'h00, 1'b0);
        chk(rdat, 8'h0F);
        for (int i = 0; i < 5; i++) begin
            wb(0, la[i], 8'h00, 1'b0);
            chk(rdat, 8'h00);
        end
        // latches: random data, read back and seen on the pins
        {d2, d3, da, db} <= {$urandom};
        for (int i = 0; i < 5; i++) begin
            lv[i] = 8'($urandom);
            wb(1, la[i], lv[i], 1'b0);
            wb(0, la[i], 8'h00, 1'b0);
            chk(rdat, lv[i] & lm[i]);
        end
        settle();
        chk(p1, lv[0]);
        chk(p2, lv[1]);
        chk({2'h0, p3}, lv[2] & 8'h3F);
        chk({4'h0, pa}, lv[3] & 8'h0F);
        chk(pb, lv[4]);
        chk({p3e, pae[1:0]}, {d3[5:0], da[1:0]});
        chk(p2e ^ pbe, d2 ^ db);
        chk(p2e, d2);
        chk(pbe, db);
        chk({pae, 4'h0}, {da[3:0], 4'h0});
        // pin state: nothing driven, writes there leave the levels alone
        d1 <= 8'h00;
        ext <= 40'({$urandom, $urandom});
        repeat (6) @(posedge clk_i);
        pe = '{ext[7:0], ext[15:8], ext[23:16], ext[31:24], {3'h0, ext[36:32]}};
        for (int i = 0; i < 5; i++) begin
            wb(1, ps[i], ~pe[i], 1'b0);
            wb(0, ps[i], 8'h00, 1'b0);
            chk(rdat, pe[i]);
        end
        wb(1, 16'hFF40, 8'hA5, 1'b1);
        wb(0, 16'hFF63, 8'h00, 1'b1);
        for (int k = 0; k < 40; k++) begin
            @(posedge clk_i);
            dg <= dg & 8'hF5;
            pfc = 8'($urandom);
            wb(1, OFF_FUNC_CTRL_1, pfc, 1'b0);
            l1 = 8'($urandom);
            wb(1, OFF_P1_LATCH, l1, 1'b0);
            mode <= (k % 2 == 0) ? 3'(4 + k % 3) : 3'($urandom);
            {d1, df, dg, ahi, cs} <= 35'({$urandom, $urandom});
            {bus_release_enable, e25, e167} <= (k < 8) ? 3'h3 : 3'($urandom);
            settle();
            chk(p1, exp_p1(pfc, l1, ahi, mode));
            chk(p1e, d1);
            cs_exp = exp_cs(pfc, df, dg, bus_release_enable, e25, e167, mode, cs);
            chk({gce, fce, {gc, fc} & {gce, fce}}, cs_exp);
        end
        wb(0, OFF_FUNC_CTRL_1, 8'h00, 1'b0);
        chk(rdat, pfc);
        summarize();
    end
endmodule
